//--- rtl/ocpf_formatter.sv
`timescale 1ns/1ns

module ocpf_formatter #(
    parameter int unsigned PADDR_W          = 12,
    parameter int unsigned RESET_IDLE_BEATS = ocpf_pkg::RESET_IDLE_BEATS
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [PADDR_W-1:0]    paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // transaction request
    input  wire logic                  reqValid,
    output logic                       reqReady,
    input  wire logic [4:0]            reqCommand,
    input  wire logic [43:0]           reqAddr,
    input  wire logic [2:0]            reqId,
    input  wire logic [7:0]            reqMask,
    input  wire logic                  reqMemory,
    input  wire logic                  reqSpec,
    input  wire logic                  reqSpecConfirm,
    // probe results
    input  wire logic                  probeValid,
    output logic                       probeReady,
    input  wire logic                  probeMiss,
    input  wire logic                  probeHitNoMove,
    // nonexistent memory report
    output logic                       nxmValid,
    output logic      [2:0]            nxmId,
    // link
    input  wire logic                  fwdClk,
    output logic      [14:0]           outboundCmdAddrBus_n
);

    if (PADDR_W < 4 || RESET_IDLE_BEATS < 1 || RESET_IDLE_BEATS > 65535) begin : g_check
        $error("ocpf_formatter: unsupported parameter value");
    end

    localparam logic [15:0] IDLE_BEATS = 16'(RESET_IDLE_BEATS);
    localparam logic [1:0]  LAST_BEAT  = 2'(ocpf_pkg::BEATS_PER_PACKET - 1);

    // registers
    logic                  layoutReg;
    logic [1:0]            narrowReg;
    logic [15:0]           nxmCountReg;
    logic [31:0]           prdataReg;
    logic                  preadyReg;
    logic                  pslverrReg;
    // link edge detection
    logic                  fwdSync1Reg;
    logic                  fwdSync2Reg;
    logic                  fwdPrevReg;
    logic                  linkEdge;
    // packet sequencing
    logic [1:0]            beatReg;
    logic [15:0]           edgeCountReg;
    logic                  resetDoneReg;
    logic                  startPkt;
    ocpf_pkg::ocpf_kind_t  kindReg;
    ocpf_pkg::ocpf_kind_t  curKind;
    logic [1:0]            curBeat;
    // held request
    logic                  holdFullReg;
    logic                  reqReadyReg;
    logic [4:0]            holdCmdReg;
    logic [43:0]           holdAddrReg;
    logic [2:0]            holdIdReg;
    logic [7:0]            holdMaskReg;
    logic                  holdRvReg;
    // packet in flight
    logic [4:0]            pktCmdReg;
    logic [43:0]           pktAddrReg;
    logic [2:0]            pktIdReg;
    logic [7:0]            pktMaskReg;
    logic                  pktRvReg;
    logic                  pktLayoutReg;
    logic [1:0]            pktNarrowReg;
    logic [4:0]            curCmd;
    logic [43:0]           curAddr;
    logic [2:0]            curId;
    logic [7:0]            curMask;
    logic                  curRv;
    logic                  curLayout;
    logic [1:0]            curNarrow;
    // probe result
    logic                  probePendReg;
    logic                  probeMissReg;
    logic                  probeNoMoveReg;
    logic                  probeReadyReg;
    logic                  m1UsedReg;
    logic                  useM1;
    logic                  useM2;
    // misc
    logic                  nxmValidReg;
    logic [2:0]            nxmIdReg;
    logic [14:0]           busReg;
    logic [14:0]           busNext;
    logic [5:0]            maxPa;
    logic                  overLimit;
    logic                  reqTake;
    logic                  apbDone;
    logic                  apbLoad;

    // beat word, positive logic, before narrowing
    function automatic logic [14:0] beatWord(
        input logic [1:0]  beat,
        input logic        layout,
        input logic        m,
        input logic        ch,
        input logic        rv,
        input logic [4:0]  cmd,
        input logic [7:0]  mask,
        input logic [2:0]  id,
        input logic [43:0] pa
    );
        logic [14:0] w;
        w = '0;
        if (layout == ocpf_pkg::LAYOUT_BANK) begin
            case (beat)
                2'h0: w = {m, cmd, pa[34:28], pa[36], pa[38]};
                2'h1: w = {pa[27:22], pa[12:6], pa[35], pa[37]};
                2'h2: w = {m, mask, ch, id, pa[40], pa[42]};
                default: w = {rv, pa[21:13], pa[5:3], pa[39], pa[41]};
            endcase
        end else begin
            case (beat)
                2'h0: w = {m, cmd, pa[31:25], pa[32], pa[33]};
                2'h1: w = {pa[24:12], pa[11], pa[34]};
                2'h2: w = {m, mask, ch, id, pa[35], pa[37]};
                default: w = {rv, pa[34:32], pa[11:3], pa[36], pa[38]};
            endcase
        end
        return w;
    endfunction

    // address limit from current configuration
    always_comb begin
        if (narrowReg == ocpf_pkg::NARROW_NO_BITS) begin
            maxPa = ocpf_pkg::MAXPA_NO_BITS;
        end else if (narrowReg == ocpf_pkg::NARROW_NO_BIT0) begin
            maxPa = ocpf_pkg::MAXPA_NO_BIT0;
        end else if (layoutReg == ocpf_pkg::LAYOUT_PAGE) begin
            maxPa = ocpf_pkg::MAXPA_PAGE_FULL;
        end else begin
            maxPa = ocpf_pkg::MAXPA_BANK_FULL;
        end
    end

    assign overLimit = reqMemory && ((reqAddr >> (maxPa + 6'h01)) != 44'h0);
    assign reqTake   = reqValid && reqReadyReg;

    // forwarded clock: two-stage sync, then rising-edge detect
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fwdSync1Reg <= 1'b0;
            fwdSync2Reg <= 1'b0;
            fwdPrevReg  <= 1'b0;
        end else begin
            fwdSync1Reg <= fwdClk;
            fwdSync2Reg <= fwdSync1Reg;
            fwdPrevReg  <= fwdSync2Reg;
        end
    end

    assign linkEdge = fwdSync2Reg && !fwdPrevReg;
    assign startPkt = linkEdge && (beatReg == LAST_BEAT);
    assign curBeat  = startPkt ? 2'h0 : beatReg + 2'h1;

    // beat counter and reset-period tracking
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            beatReg      <= LAST_BEAT;
            edgeCountReg <= 16'h0000;
            resetDoneReg <= 1'b0;
        end else if (linkEdge) begin
            beatReg <= curBeat;
            if (edgeCountReg != IDLE_BEATS) begin
                edgeCountReg <= edgeCountReg + 16'h0001;
            end
            // only switch at a packet boundary; sticky afterwards
            if (startPkt && edgeCountReg == IDLE_BEATS) begin
                resetDoneReg <= 1'b1;
            end
        end
    end

    // packet source: new packet at its first beat, else the latched one
    always_comb begin
        if (!startPkt) begin
            curKind = kindReg;
        end else if (!resetDoneReg) begin
            curKind = ocpf_pkg::PKT_ZERO;
        end else if (holdFullReg) begin
            curKind = ocpf_pkg::PKT_CMD;
        end else begin
            curKind = ocpf_pkg::PKT_IDLE;
        end
        curLayout = startPkt ? layoutReg : pktLayoutReg;
        curNarrow = startPkt ? narrowReg : pktNarrowReg;
        if (startPkt && curKind == ocpf_pkg::PKT_CMD) begin
            curCmd  = holdCmdReg;
            curAddr = holdAddrReg;
            curId   = holdIdReg;
            curMask = holdMaskReg;
            curRv   = holdRvReg;
        end else if (startPkt) begin
            curCmd  = ocpf_pkg::CMD_NONZERO_IDLE;
            curAddr = 44'h0;
            curId   = 3'h0;
            curMask = 8'h00;
            curRv   = 1'b1;
        end else begin
            curCmd  = pktCmdReg;
            curAddr = pktAddrReg;
            curId   = pktIdReg;
            curMask = pktMaskReg;
            curRv   = pktRvReg;
        end
    end

    // probe miss takes the first free miss-flag slot; a hit can take only the second
    assign useM1 = linkEdge && curBeat == 2'h0 && curKind != ocpf_pkg::PKT_ZERO
                   && probePendReg && probeMissReg;
    assign useM2 = linkEdge && curBeat == 2'h2 && curKind != ocpf_pkg::PKT_ZERO
                   && probePendReg && !m1UsedReg;

    always_comb begin
        busNext = beatWord(curBeat, curLayout, useM1 || useM2, useM2 && probeNoMoveReg,
                           curRv, curCmd, curMask, curId, curAddr);
        if (curKind == ocpf_pkg::PKT_ZERO) begin
            busNext = 15'h0000;
        end else if (curNarrow == ocpf_pkg::NARROW_NO_BITS) begin
            busNext[1:0] = 2'h0;
        end else if (curNarrow == ocpf_pkg::NARROW_NO_BIT0) begin
            busNext[0] = 1'b0;
        end
    end

    // flop holds pin levels, so the bus leaves a register; reset is the zero idle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busReg <= 15'h7FFF;
        end else if (linkEdge) begin
            busReg <= ~busNext;
        end
    end

    assign outboundCmdAddrBus_n = busReg;

    // latch packet contents at its first beat
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            kindReg      <= ocpf_pkg::PKT_ZERO;
            pktCmdReg    <= ocpf_pkg::CMD_IDLE_ZERO;
            pktAddrReg   <= 44'h0;
            pktIdReg     <= 3'h0;
            pktMaskReg   <= 8'h00;
            pktRvReg     <= 1'b0;
            pktLayoutReg <= ocpf_pkg::LAYOUT_RESET;
            pktNarrowReg <= ocpf_pkg::NARROW_RESET;
        end else if (startPkt) begin
            kindReg      <= curKind;
            pktCmdReg    <= curCmd;
            pktAddrReg   <= curAddr;
            pktIdReg     <= curId;
            pktMaskReg   <= curMask;
            pktRvReg     <= curRv;
            pktLayoutReg <= curLayout;
            pktNarrowReg <= curNarrow;
        end
    end

    // one-deep request holding slot
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            holdFullReg <= 1'b0;
            reqReadyReg <= 1'b0;
            holdCmdReg  <= 5'h00;
            holdAddrReg <= 44'h0;
            holdIdReg   <= 3'h0;
            holdMaskReg <= 8'h00;
            holdRvReg   <= 1'b0;
        end else begin
            if (reqTake && !overLimit) begin
                holdFullReg <= 1'b1;
                reqReadyReg <= 1'b0;
                holdCmdReg  <= reqCommand;
                holdAddrReg <= reqAddr;
                holdIdReg   <= reqId;
                holdMaskReg <= reqMask;
                holdRvReg   <= !reqSpec || reqSpecConfirm;
            end else if (startPkt && curKind == ocpf_pkg::PKT_CMD) begin
                holdFullReg <= 1'b0;
                reqReadyReg <= 1'b1;
            end else begin
                reqReadyReg <= !holdFullReg;
            end
        end
    end

    // over-limit accesses never reach the bus
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nxmValidReg <= 1'b0;
            nxmIdReg    <= 3'h0;
            nxmCountReg <= 16'h0000;
        end else begin
            nxmValidReg <= reqTake && overLimit;
            if (reqTake && overLimit) begin
                nxmIdReg    <= reqId;
                nxmCountReg <= nxmCountReg + 16'h0001;
            end
        end
    end

    // single pending probe result
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            probePendReg   <= 1'b0;
            probeMissReg   <= 1'b0;
            probeNoMoveReg <= 1'b0;
            probeReadyReg  <= 1'b0;
            m1UsedReg      <= 1'b0;
        end else begin
            if (probeValid && probeReadyReg) begin
                probePendReg   <= 1'b1;
                probeMissReg   <= probeMiss;
                probeNoMoveReg <= probeHitNoMove && !probeMiss;
                probeReadyReg  <= 1'b0;
            end else if (useM1 || useM2) begin
                probePendReg  <= 1'b0;
                probeReadyReg <= 1'b1;
            end else begin
                probeReadyReg <= !probePendReg;
            end
            if (linkEdge && curBeat == 2'h0) begin
                m1UsedReg <= useM1;
            end
        end
    end

    // apb: pready one cycle into the access phase, effect at its edge
    assign apbLoad = psel && penable && !preadyReg;
    assign apbDone = psel && penable && preadyReg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            preadyReg  <= 1'b0;
            pslverrReg <= 1'b0;
            prdataReg  <= 32'h0000_0000;
        end else begin
            preadyReg  <= apbLoad;
            pslverrReg <= 1'b0;
            prdataReg  <= 32'h0000_0000;
            if (apbLoad) begin
                if (paddr == PADDR_W'(ocpf_pkg::CTRL_OFFSET)) begin
                    prdataReg[ocpf_pkg::CTRL_LAYOUT_BIT] <= layoutReg;
                    prdataReg[ocpf_pkg::CTRL_NARROW_LSB +: 2] <= narrowReg;
                    // illegal narrow code is refused, old value kept
                    pslverrReg <= pwrite && pwdata[ocpf_pkg::CTRL_NARROW_LSB +: 2]
                                  == ocpf_pkg::NARROW_ILLEGAL;
                end else if (paddr == PADDR_W'(ocpf_pkg::STATUS_OFFSET)) begin
                    prdataReg[ocpf_pkg::STATUS_DONE_BIT]  <= resetDoneReg;
                    prdataReg[ocpf_pkg::STATUS_HOLD_BIT]  <= holdFullReg;
                    prdataReg[ocpf_pkg::STATUS_PROBE_BIT] <= probePendReg;
                    prdataReg[ocpf_pkg::STATUS_BEAT_LSB +: 2] <= beatReg;
                    pslverrReg <= pwrite;
                end else if (paddr == PADDR_W'(ocpf_pkg::NXM_COUNT_OFFSET)) begin
                    prdataReg[15:0] <= nxmCountReg;
                    pslverrReg      <= pwrite;
                end else begin
                    pslverrReg <= 1'b1;
                end
            end
        end
    end

    // configuration, applied to the bus from the next packet boundary, to the address limit at once
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            layoutReg <= ocpf_pkg::LAYOUT_RESET;
            narrowReg <= ocpf_pkg::NARROW_RESET;
        end else if (apbDone && pwrite && !pslverrReg
                     && paddr == PADDR_W'(ocpf_pkg::CTRL_OFFSET)) begin
            layoutReg <= pwdata[ocpf_pkg::CTRL_LAYOUT_BIT];
            narrowReg <= pwdata[ocpf_pkg::CTRL_NARROW_LSB +: 2];
        end
    end

    assign prdata     = prdataReg;
    assign pready     = preadyReg;
    assign pslverr    = pslverrReg;
    assign reqReady   = reqReadyReg;
    assign probeReady = probeReadyReg;
    assign nxmValid   = nxmValidReg;
    assign nxmId      = nxmIdReg;

endmodule

//--- rtl/ocpf_pkg.sv
package ocpf_pkg;

    // register byte offsets
    localparam logic [11:0] CTRL_OFFSET      = 12'h000;
    localparam logic [11:0] STATUS_OFFSET    = 12'h004;
    localparam logic [11:0] NXM_COUNT_OFFSET = 12'h008;

    // control field positions and reset values
    localparam int          CTRL_LAYOUT_BIT   = 0;
    localparam int          CTRL_NARROW_LSB   = 1;
    localparam logic        LAYOUT_RESET      = 1'h0;
    localparam logic [1:0]  NARROW_RESET      = 2'h0;

    // status field positions
    localparam int          STATUS_DONE_BIT   = 0;
    localparam int          STATUS_HOLD_BIT   = 1;
    localparam int          STATUS_PROBE_BIT  = 2;
    localparam int          STATUS_BEAT_LSB   = 3;

    // address layouts and narrow-bus settings
    localparam logic        LAYOUT_BANK       = 1'h0;
    localparam logic        LAYOUT_PAGE       = 1'h1;
    localparam logic [1:0]  NARROW_FULL       = 2'h0;
    localparam logic [1:0]  NARROW_NO_BIT0    = 2'h1;
    localparam logic [1:0]  NARROW_ILLEGAL    = 2'h2;
    localparam logic [1:0]  NARROW_NO_BITS    = 2'h3;

    // highest usable physical address bit per setting
    localparam logic [5:0]  MAXPA_BANK_FULL   = 6'h2A;
    localparam logic [5:0]  MAXPA_PAGE_FULL   = 6'h26;
    localparam logic [5:0]  MAXPA_NO_BIT0     = 6'h24;
    localparam logic [5:0]  MAXPA_NO_BITS     = 6'h22;

    // command codes
    localparam logic [4:0]  CMD_IDLE_ZERO     = 5'h00;
    localparam logic [4:0]  CMD_NONZERO_IDLE  = 5'h02;

    // packet shape and timing
    localparam int          BEATS_PER_PACKET  = 4;
    localparam int          RESET_IDLE_BEATS  = 16;
    localparam int          PA_WIDTH          = 44;

    typedef enum {
        PKT_ZERO,
        PKT_IDLE,
        PKT_CMD
    } ocpf_kind_t;

endpackage

//--- testbench/ocpf_formatter_monitor.sv
`timescale 1ns/1ns
module ocpf_formatter_monitor (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    // request, probe, nxm
    input wire logic        reqValid,
    input wire logic        reqReady,
    input wire logic        reqMemory,
    input wire logic [2:0]  reqId,
    input wire logic        probeValid,
    input wire logic        probeReady,
    input wire logic        nxmValid,
    input wire logic [2:0]  nxmId,
    // link
    input wire logic [14:0] outboundCmdAddrBus_n
);
    logic takenMem;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    assign takenMem = reqValid & reqReady & reqMemory;

    sequence reqTaken;
        reqValid && reqReady;
    endsequence
    sequence apbFirst;
        psel && $rose(penable);
    endsequence

    chk_req_held: assert property (reqTaken ##0 !reqMemory |=> !reqReady)
        else $error("request slot not held");
    chk_req_back: assert property ($fell(reqReady) |-> ##[1:120] reqReady)
        else $error("request slot not freed");
    chk_nxm_cause: assert property (nxmValid |-> $past(takenMem) || $past(takenMem, 2))
        else $error("nxm without memory request");
    chk_nxm_id: assert property (nxmValid |-> nxmId == $past(reqId) || nxmId == $past(reqId, 2))
        else $error("nxm id wrong");
    chk_probe_slot: assert property (probeValid && probeReady |=> !probeReady)
        else $error("probe slot not taken");
    chk_reset_idle: assert property ($rose(rst_n) |-> outboundCmdAddrBus_n == 15'h7FFF)
        else $error("bus not idle after reset");
    chk_beat_stands: assert property ($changed(outboundCmdAddrBus_n) |=> $stable(outboundCmdAddrBus_n)[*6])
        else $error("beat too short");
    chk_apb_wait: assert property (apbFirst |-> !pready ##1 pready)
        else $error("apb answer late");
endmodule

//--- testbench/ocpf_sys_model.sv
`timescale 1ns/1ns
module ocpf_sys_model (
    // link
    output logic             fwdClk,
    input  wire logic        rst_n,
    input  wire logic [14:0] outboundCmdAddrBus_n,
    // captured packets
    output logic [59:0]      pktWord,
    output int               pktCount,
    output int               zeroCmds
);
    logic [14:0] beat;
    logic [44:0] acc;
    logic [1:0]  idx;
    logic        framed;

    initial fwdClk = 1'b0;
    // free running, as the controller's own forwarded clock
    always #80 fwdClk = ~fwdClk;
    assign beat = ~outboundCmdAddrBus_n;
    // sampled at the next rising edge, the beat having changed on the third ref_clk edge after the one before;
    // bits 1:0 are kept although a small system could tie them
    always @(posedge fwdClk or negedge rst_n) begin
        if (!rst_n) begin
            framed <= 1'b0;
            idx <= 2'h0;
            pktCount <= 0;
            zeroCmds <= 0;
        end else if (framed || beat != 15'h0) begin
            framed <= 1'b1;
            idx <= idx + 2'h1;
            acc <= {acc[29:0], beat};
            if (idx == 2'h0 && beat[13:9] == 5'h00) zeroCmds <= zeroCmds + 1;
            if (idx == 2'h3) begin
                pktWord <= {acc, beat};
                pktCount <= pktCount + 1;
            end
        end
    end
endmodule

//--- testbench/tb_ocpf_formatter.sv
`timescale 1ns/1ns
module tb_ocpf_formatter;
    logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        reqValid = 1'b0, reqMemory = 1'b0, reqSpec = 1'b0, reqSpecConfirm = 1'b0;
    logic [4:0]  reqCommand = 5'h00;
    logic [43:0] reqAddr = 44'h0;
    logic [2:0]  reqId = 3'h0, nxmId, nxmIdSeen = 3'h0;
    logic [7:0]  reqMask = 8'h00;
    logic        probeValid = 1'b0, probeMiss = 1'b0, probeHitNoMove = 1'b0, nxmSeen = 1'b0;
    logic        pready, pslverr, reqReady, probeReady, nxmValid, fwdClk;
    logic [14:0] cmdBus_n;
    logic [59:0] pktWord;
    int          pktCount, zeroCmds, errTotal = 0, checked = 0;

    ocpf_formatter #(.RESET_IDLE_BEATS(8)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reqValid(reqValid), .reqReady(reqReady), .reqCommand(reqCommand), .reqAddr(reqAddr),
        .reqId(reqId), .reqMask(reqMask), .reqMemory(reqMemory), .reqSpec(reqSpec),
        .reqSpecConfirm(reqSpecConfirm), .probeValid(probeValid), .probeReady(probeReady),
        .probeMiss(probeMiss), .probeHitNoMove(probeHitNoMove), .nxmValid(nxmValid),
        .nxmId(nxmId), .fwdClk(fwdClk), .outboundCmdAddrBus_n(cmdBus_n));
    ocpf_sys_model model (.fwdClk(fwdClk), .rst_n(rst_n), .outboundCmdAddrBus_n(cmdBus_n),
        .pktWord(pktWord), .pktCount(pktCount), .zeroCmds(zeroCmds));

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (nxmValid === 1'b1) begin
            nxmSeen <= 1'b1;
            nxmIdSeen <= nxmId;
        end
    end

    function automatic logic [59:0] pkt(logic lay, logic [1:0] nar, logic [4:0] cmd,
        logic [43:0] pa, logic [7:0] mask, logic [2:0] id, logic rv);
        logic [14:0] b [4];
        if (lay == 1'b0) begin
            b[0] = {1'b0, cmd, pa[34:28], pa[36], pa[38]};
            b[1] = {pa[27:22], pa[12:6], pa[35], pa[37]};
            b[2] = {1'b0, mask, 1'b0, id, pa[40], pa[42]};
            b[3] = {rv, pa[21:13], pa[5:3], pa[39], pa[41]};
        end else begin
            b[0] = {1'b0, cmd, pa[31:25], pa[32], pa[33]};
            b[1] = {pa[24:12], pa[11], pa[34]};
            b[2] = {1'b0, mask, 1'b0, id, pa[35], pa[37]};
            b[3] = {rv, pa[34:32], pa[11:3], pa[36], pa[38]};
        end
        for (int i = 0; i < 4; i++) begin
            b[i][0] &= (nar == 2'h0);
            b[i][1] &= (nar != 2'h3);
        end
        return {b[0], b[1], b[2], b[3]};
    endfunction

    task automatic stopTest;
        $display("comparisons %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [59:0] got, input logic [59:0] exp);
        checked++;
        if (got !== exp) begin
            errTotal++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic sendReq(input logic [4:0] c, input logic [43:0] pa, input logic [2:0] id,
        input logic [7:0] mask, input logic mem, input logic spec, input logic conf);
        @(posedge ref_clk);
        reqValid <= 1'b1;
        reqCommand <= c;
        reqAddr <= pa;
        reqId <= id;
        reqMask <= mask;
        reqMemory <= mem;
        reqSpec <= spec;
        reqSpecConfirm <= conf;
        do @(posedge ref_clk); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
    endtask

    task automatic sendProbe(input logic miss, input logic hnm);
        @(posedge ref_clk);
        probeValid <= 1'b1;
        probeMiss <= miss;
        probeHitNoMove <= hnm;
        do @(posedge ref_clk); while (probeReady !== 1'b1);
        probeValid <= 1'b0;
    endtask

    task automatic nextPkt(output logic [59:0] w);
        int n;
        n = pktCount;
        for (int i = 0; i < 300 && pktCount == n; i++) @(negedge ref_clk);
        w = pktWord;
    endtask

    // gives up after four packets and hands back the last one seen
    task automatic findCmd(input logic [4:0] c, output logic [59:0] w);
        for (int i = 0; i < 4; i++) begin
            nextPkt(w);
            if (w[58:54] === c) break;
        end
    endtask

    // a full run needs about 1600 cycles
    initial begin
        repeat (40000) @(posedge ref_clk);
        errTotal++;
        stopTest;
    end

    initial begin
        logic [59:0] w, w2;
        logic [31:0] rd;
        logic        err, lay;
        logic [1:0]  nar;
        logic [4:0]  c;
        logic [43:0] pa;
        logic [3:0]  v;
        logic [5:0]  maxTab [6];
        maxTab = '{6'h2A, 6'h24, 6'h22, 6'h26, 6'h24, 6'h22};
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        nextPkt(w);
        cmp(w, pkt(1'h0, 2'h0, 5'h02, 44'h0, 8'h00, 3'h0, 1'h1));
        apb(1'h0, ocpf_pkg::CTRL_OFFSET, 32'h0, rd, err);
        cmp({28'h0, rd}, 60'h0);
        apb(1'h1, ocpf_pkg::CTRL_OFFSET, 32'h4, rd, err);
        cmp({59'h0, err}, 60'h1);
        apb(1'h0, ocpf_pkg::CTRL_OFFSET, 32'h0, rd, err);
        cmp({28'h0, rd}, 60'h0);
        apb(1'h1, ocpf_pkg::STATUS_OFFSET, 32'hF, rd, err);
        apb(1'h0, 12'h00C, 32'h0, rd, err);
        cmp({27'h0, err, rd}, 60'h100000000);
        for (int k = 0; k < 6; k++) begin
            lay = (k >= 3);
            nar = (k % 3 == 2) ? 2'h3 : 2'(k % 3);
            c = 5'h10 + 5'(k);
            apb(1'h1, ocpf_pkg::CTRL_OFFSET, {29'h0, nar, lay}, rd, err);
            pa = 44'hE5C_369F_1B8C & ((44'h1 << (maxTab[k] + 6'h1)) - 44'h1);
            sendReq(c, pa, 3'(k), 8'hA5, 1'h1, 1'h0, 1'h0);
            findCmd(c, w);
            cmp(w, pkt(lay, nar, c, pa, 8'hA5, 3'(k), 1'h1));
            nxmSeen = 1'b0;
            sendReq(5'h11, pa | (44'h1 << (maxTab[k] + 6'h1)), 3'h5, 8'h00, 1'h1, 1'h0, 1'h0);
            repeat (4) @(negedge ref_clk);
            cmp({56'h0, nxmSeen, nxmIdSeen}, {56'h0, 4'hD});
            findCmd(5'h11, w);
            cmp({59'h0, w[58:54] === 5'h11}, 60'h0);
        end
        pa = 44'h400_1234_5678;
        sendReq(5'h08, pa, 3'h6, 8'h0F, 1'h0, 1'h0, 1'h0);
        findCmd(5'h08, w);
        cmp(w, pkt(1'h1, 2'h3, 5'h08, pa, 8'h0F, 3'h6, 1'h1));
        for (int k = 0; k < 2; k++) begin
            sendReq(5'h14, 44'h0, 3'h1, 8'h00, 1'h1, 1'h1, k[0]);
            findCmd(5'h14, w);
            cmp(w, pkt(1'h1, 2'h3, 5'h14, 44'h0, 8'h00, 3'h1, k[0]));
        end
        for (int k = 0; k < 2; k++) begin
            sendProbe(k == 0, k == 1);
            nextPkt(w);
            nextPkt(w2);
            v = {w[59] & w[29] | w2[59] & w2[29], (w[59] | w[29]) ^ (w2[59] | w2[29]),
                 w[20] | w2[20], (w[29] & w[20]) | (w2[29] & w2[20])};
            cmp({56'h0, v}, {58'h1, k[0], k[0]});
        end
        apb(1'h0, ocpf_pkg::NXM_COUNT_OFFSET, 32'h0, rd, err);
        cmp({28'h0, rd}, 60'h6);
        cmp(60'(zeroCmds), 60'h0);
        stopTest;
    end
endmodule

bind ocpf_formatter ocpf_formatter_monitor mon (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
    .reqValid(reqValid), .reqReady(reqReady), .reqMemory(reqMemory), .reqId(reqId),
    .probeValid(probeValid), .probeReady(probeReady), .nxmValid(nxmValid), .nxmId(nxmId),
    .outboundCmdAddrBus_n(outboundCmdAddrBus_n));
